// ===== clkdiv_pkg.sv
package clkdiv_pkg;
	// register addresses on the configuration port
	localparam int ADDR_W = 10;
	localparam logic [9:0] ADDR_COUNTS = 10'h199;
	localparam logic [9:0] ADDR_CTRL = 10'h19A;
	localparam logic [9:0] ADDR_CFG = 10'h19B;
	localparam logic [9:0] ADDR_PRESC = 10'h1E0;
	localparam logic [9:0] ADDR_SRC = 10'h1E1;
	// reset values
	localparam logic [7:0] RST_COUNTS = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [2:0] RST_PRESC = 3'h0;
	localparam logic [1:0] RST_SRC = 2'h0;
	// implemented bits; everything else reads as zero
	localparam logic [7:0] MASK_CFG = 8'h07;
	localparam int PRESC_LSB = 0;
	localparam int PRESC_W = 3;
	localparam int SRC_W = 2;
	localparam int CNT_W = 4;
	// source-select codes for the direct route
	localparam logic [1:0] SRC_EXT = 2'h0;
	localparam logic [1:0] SRC_NONE = 2'h1;
	localparam logic [1:0] SRC_OSC = 2'h2;

	// divider control register, bit 7 down to bit 0
	typedef struct packed {
		logic bypass;
		logic ign_sync;
		logic force_lvl;
		logic start_high;
		logic [3:0] phase;
	} ctrl_s;

	// channel output configuration register
	typedef struct packed {
		logic [4:0] unused;
		logic pwr_down;
		logic direct;
		logic dcc_off;
	} cfg_s;

	// half-period counts, each minus one
	typedef struct packed {
		logic [3:0] low_cnt;
		logic [3:0] high_cnt;
	} counts_s;

	// divider sequencer states
	typedef enum logic {
		ST_RUN,
		ST_WAIT
	} div_state_e;
endpackage : clkdiv_pkg

// ===== clkdiv_core.sv
`timescale 1ns/1ps
module clkdiv_core (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_enable,
	input wire logic i_restart,
	input wire logic i_start_high,
	input wire logic [3:0] i_phase,
	input wire clkdiv_pkg::counts_s i_counts,
	output logic o_level,
	output logic o_waiting
);
	////////////////////////////////////////////////////////////////////////
	clkdiv_pkg::div_state_e state_ff, nxt_state; // sequencer state
	logic level_ff, nxt_level; // divided clock level
	logic [3:0] cnt_ff, nxt_cnt; // cycles left in this half
	logic [3:0] phase_ff, nxt_phase; // cycles left before restart runs
	wire logic [3:0] half_start = i_start_high ? i_counts.high_cnt : i_counts.low_cnt;
	wire logic [3:0] half_flip = level_ff ? i_counts.low_cnt : i_counts.high_cnt;
	wire logic [3:0] half_cur = level_ff ? i_counts.high_cnt : i_counts.low_cnt;

	assign o_level = level_ff;
	assign o_waiting = (state_ff == clkdiv_pkg::ST_WAIT);

	////////////////////////////////////////////////////////////////////////
	// next-state logic of the divider
	always_comb begin
		nxt_state = state_ff;
		nxt_level = level_ff;
		nxt_cnt = cnt_ff;
		nxt_phase = phase_ff;
		if (!i_enable) begin
			// parked at the start level so a later enable begins cleanly
			nxt_state = clkdiv_pkg::ST_RUN;
			nxt_level = i_start_high;
			nxt_cnt = half_start;
		end else if (i_restart) begin
			nxt_level = i_start_high;
			nxt_phase = i_phase;
			nxt_cnt = half_start;
			nxt_state = (i_phase == 4'h0) ? clkdiv_pkg::ST_RUN : clkdiv_pkg::ST_WAIT;
		end else begin
			unique case (state_ff)
				clkdiv_pkg::ST_RUN: begin
					if (cnt_ff == 4'h0) begin
						nxt_level = ~level_ff;
						nxt_cnt = half_flip;
					end else begin
						nxt_cnt = cnt_ff - 4'h1;
					end
				end
				clkdiv_pkg::ST_WAIT: begin
					if (phase_ff <= 4'h1) begin
						nxt_state = clkdiv_pkg::ST_RUN;
						nxt_cnt = half_cur;
					end else begin
						nxt_phase = phase_ff - 4'h1;
					end
				end
			endcase
		end
	end

	// state registers, frozen while clock enable is low
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= clkdiv_pkg::ST_RUN;
			level_ff <= 1'b0;
			cnt_ff <= 4'h0;
			phase_ff <= 4'h0;
		end else if (i_ce) begin
			state_ff <= nxt_state;
			level_ff <= nxt_level;
			cnt_ff <= nxt_cnt;
			phase_ff <= nxt_phase;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	a_half_hold: assert property (i_ce && i_enable && !i_restart && state_ff == clkdiv_pkg::ST_RUN && cnt_ff != 4'h0
		|=> $stable(level_ff) && cnt_ff == $past(cnt_ff) - 4'h1) else $error("level moved mid half");
	a_half_toggle: assert property (i_ce && i_enable && !i_restart && state_ff == clkdiv_pkg::ST_RUN && cnt_ff == 4'h0
		|=> level_ff != $past(level_ff) && cnt_ff == $past(half_flip)) else $error("bad half reload");
	a_phase_wait: assert property (i_ce && i_enable && i_restart && i_phase != 4'h0
		|=> state_ff == clkdiv_pkg::ST_WAIT && phase_ff == $past(i_phase) && level_ff == $past(i_start_high))
		else $error("restart did not wait");
	a_wait_end: assert property (i_ce && i_enable && !i_restart && state_ff == clkdiv_pkg::ST_WAIT && phase_ff == 4'h1
		|=> state_ff == clkdiv_pkg::ST_RUN && $stable(level_ff)) else $error("wait overran");
	c_phase_restart: cover property (i_ce && i_enable && i_restart && i_phase == 4'h2 ##1 o_waiting [*2]);
endmodule : clkdiv_core

// ===== channel_divider_control.sv
`timescale 1ns/1ps
// Function
// - bypass powers divider down, passes input through
// - ignore bit makes divider disregard sync
// - force, with the ignore bit set, holds output at start level
// - force void when bypassed; inversion still works
// - start bit picks high or low start
// - four-bit phase offset, resets to zero
// - power-down forces all three outputs safe
// - direct route selects oscillator or external
// - direct bit clear drives from divider
// - bit zero set disables duty correction
// - three-bit prescaler ratio, zero divides two
// - low/high counts plus one per half
module channel_divider_control (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [9:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_sync,
	input wire logic i_dist_lvl,
	input wire logic i_osc_lvl,
	input wire logic i_ext_lvl,
	input wire logic i_drv_invert,
	output logic [7:0] o_reg_rdata,
	output logic [2:0] o_ch_out,
	output logic o_div_pd,
	output logic o_dcc_en,
	output logic [2:0] o_prescale_ratio
);
	////////////////////////////////////////////////////////////////////////
	// register state, one flop group per address
	clkdiv_pkg::counts_s counts_ff; // half-period counts
	clkdiv_pkg::ctrl_s ctrl_ff; // divider control
	clkdiv_pkg::cfg_s cfg_ff; // channel output configuration
	logic [2:0] presc_ff; // prescaler ratio code
	logic [1:0] src_ff; // direct-route source select
	logic [7:0] rdata_ff; // read data holding register
	logic [2:0] out_ff; // channel output levels
	logic div_pd_ff; // divider power-down indication
	logic dcc_ff; // duty correction enable
	// handshake with the counting core
	logic core_level; // divided clock from the core
	logic core_wait; // core is waiting out the phase offset

	// address decode
	// full ten-bit compare, so no alias lands on a neighbouring channel
	wire logic hit_counts = (i_reg_addr == clkdiv_pkg::ADDR_COUNTS);
	wire logic hit_ctrl = (i_reg_addr == clkdiv_pkg::ADDR_CTRL);
	wire logic hit_cfg = (i_reg_addr == clkdiv_pkg::ADDR_CFG);
	wire logic hit_presc = (i_reg_addr == clkdiv_pkg::ADDR_PRESC);
	wire logic hit_src = (i_reg_addr == clkdiv_pkg::ADDR_SRC);
	// read mux; unmapped addresses and unused bits read zero
	wire logic [7:0] rd_mux = hit_counts ? 8'(counts_ff) :
		hit_ctrl ? 8'(ctrl_ff) :
		hit_cfg ? (8'(cfg_ff) & clkdiv_pkg::MASK_CFG) :
		hit_presc ? {5'h00, presc_ff} :
		hit_src ? {6'h00, src_ff} : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// divider off when bypassed or channel powered down
	wire logic div_en = ~ctrl_ff.bypass & ~cfg_ff.pwr_down;
	// sync only reaches an obeying divider
	wire logic restart = i_sync & ~ctrl_ff.ign_sync;
	// force needs the ignore bit as well
	wire logic force_act = ctrl_ff.force_lvl & ctrl_ff.ign_sync & ~ctrl_ff.bypass;
	// forced level is the start level
	wire logic div_lvl = force_act ? ctrl_ff.start_high : core_level;
	// direct route to oscillator or external clock
	wire logic route_osc = cfg_ff.direct & (src_ff == clkdiv_pkg::SRC_OSC);
	wire logic route_ext = cfg_ff.direct & (src_ff == clkdiv_pkg::SRC_EXT);
	// otherwise the divider (or its bypass) drives; code 01b changes nothing
	// code 11b falls through the same way as 01b
	wire logic path_lvl = route_osc ? i_osc_lvl :
		route_ext ? i_ext_lvl :
		ctrl_ff.bypass ? i_dist_lvl : div_lvl;
	// polarity inversion applies on every path
	// powered-down channel parks all outputs low
	wire logic nxt_out = cfg_ff.pwr_down ? 1'b0 : (path_lvl ^ i_drv_invert);

	////////////////////////////////////////////////////////////////////////
	// divider settings registers
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			// fields return to their power-up defaults
			counts_ff <= clkdiv_pkg::counts_s'(clkdiv_pkg::RST_COUNTS);
			ctrl_ff <= clkdiv_pkg::ctrl_s'(clkdiv_pkg::RST_CTRL);
		end else if (i_ce) begin
			// a write lands only on an enabled edge
			// new counts apply at the next half reload, not mid-half
			if (i_reg_wr && hit_counts) begin
				counts_ff <= clkdiv_pkg::counts_s'(i_reg_wdata);
			end
			// a new phase only matters at the next sync restart
			if (i_reg_wr && hit_ctrl) begin
				ctrl_ff <= clkdiv_pkg::ctrl_s'(i_reg_wdata);
			end
		end
	end

	// channel config, prescaler and source registers
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			// zero ratio code means divide by two
			cfg_ff <= clkdiv_pkg::cfg_s'(clkdiv_pkg::RST_CFG);
			presc_ff <= clkdiv_pkg::RST_PRESC;
			src_ff <= clkdiv_pkg::RST_SRC;
		end else if (i_ce) begin
			// unused bits are dropped so they read back zero
			if (i_reg_wr && hit_cfg) begin
				cfg_ff <= clkdiv_pkg::cfg_s'(i_reg_wdata & clkdiv_pkg::MASK_CFG);
			end
			// ratio goes straight to its port, no staging
			if (i_reg_wr && hit_presc) begin
				presc_ff <= i_reg_wdata[clkdiv_pkg::PRESC_LSB +: clkdiv_pkg::PRESC_W];
			end
			// only the select bits are kept; the rest of that address is not ours
			if (i_reg_wr && hit_src) begin
				src_ff <= i_reg_wdata[clkdiv_pkg::SRC_W-1:0];
			end
		end
	end

	// read data stays until the next read
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_ff <= 8'h00;
		end else if (i_ce && i_reg_rd) begin
			// unmapped reads capture zero from the mux
			rdata_ff <= rd_mux;
		end
	end

	// outputs retimed so every port leaves a flip-flop
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			// outputs parked low, correction enabled
			out_ff <= 3'h0;
			div_pd_ff <= 1'b0;
			dcc_ff <= 1'b1;
		end else if (i_ce) begin
			// one edge of latency on every output path keeps them aligned
			out_ff <= {3{nxt_out}};
			div_pd_ff <= ~div_en;
			dcc_ff <= ~cfg_ff.dcc_off;
		end
	end

	// ports straight from their flip-flops
	assign o_reg_rdata = rdata_ff;
	assign o_ch_out = out_ff;
	assign o_div_pd = div_pd_ff;
	assign o_dcc_en = dcc_ff;
	assign o_prescale_ratio = presc_ff;

	////////////////////////////////////////////////////////////////////////
	// the counting sequencer; one enable cycle is one divider input cycle
	clkdiv_core u_core (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_ce(i_ce),
		.i_enable(div_en),
		.i_restart(restart),
		.i_start_high(ctrl_ff.start_high),
		.i_phase(ctrl_ff.phase),
		.i_counts(counts_ff),
		.o_level(core_level),
		.o_waiting(core_wait)
	);

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	// output path, checked one edge after its inputs
	a_pd_safe: assert property (i_ce && cfg_ff.pwr_down |=> o_ch_out == 3'h0)
		else $error("powered-down channel not low");
	a_bypass_pass: assert property (i_ce && !cfg_ff.pwr_down && !route_osc && !route_ext && ctrl_ff.bypass
		|=> o_ch_out == {3{$past(i_dist_lvl ^ i_drv_invert)}}) else $error("bypass not passing input");
	a_bypass_pd: assert property (i_ce && ctrl_ff.bypass |=> o_div_pd) else $error("divider not off in bypass");
	a_force_hold: assert property (i_ce && force_act && !cfg_ff.pwr_down && !route_osc && !route_ext
		|=> o_ch_out == {3{$past(ctrl_ff.start_high ^ i_drv_invert)}}) else $error("force level wrong");
	a_osc_route: assert property (i_ce && !cfg_ff.pwr_down && route_osc
		|=> o_ch_out == {3{$past(i_osc_lvl ^ i_drv_invert)}}) else $error("oscillator route wrong");
	a_ext_route: assert property (i_ce && !cfg_ff.pwr_down && route_ext
		|=> o_ch_out == {3{$past(i_ext_lvl ^ i_drv_invert)}}) else $error("external route wrong");
	a_div_drive: assert property (i_ce && !cfg_ff.pwr_down && !cfg_ff.direct && !ctrl_ff.bypass && !force_act
		|=> o_ch_out == {3{$past(core_level ^ i_drv_invert)}}) else $error("divider not driving");
	a_src_none: assert property (i_ce && !cfg_ff.pwr_down && cfg_ff.direct && src_ff == clkdiv_pkg::SRC_NONE && force_act
		|=> o_ch_out == {3{$past(ctrl_ff.start_high ^ i_drv_invert)}}) else $error("no-effect code rerouted");

	// register side and sync
	a_pd_div: assert property (i_ce && cfg_ff.pwr_down |=> o_div_pd)
		else $error("divider not off in power-down");
	a_dcc_bit: assert property (i_ce |=> o_dcc_en == !$past(cfg_ff.dcc_off)) else $error("duty correction bit");
	a_presc_wr: assert property (i_ce && i_reg_wr && hit_presc
		|=> o_prescale_ratio == $past(i_reg_wdata[2:0])) else $error("prescaler write lost");
	a_sync_obey: assert property (i_ce && i_sync && !ctrl_ff.ign_sync && div_en
		|=> core_level == $past(ctrl_ff.start_high)) else $error("sync did not restart");
	a_sync_ignore: assert property (i_ce && i_sync && ctrl_ff.ign_sync && !core_wait
		|=> !core_wait) else $error("ignored sync restarted divider");
	a_ctrl_read: assert property (i_ce && i_reg_rd && hit_ctrl
		|=> o_reg_rdata == 8'($past(ctrl_ff))) else $error("control readback wrong");
	a_rdata_hold: assert property (!(i_ce && i_reg_rd) |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");

	// scenarios worth seeing at least once
	c_sync_restart: cover property (i_ce && restart && div_en && ctrl_ff.phase != 4'h0);
	c_bypass: cover property (i_ce && ctrl_ff.bypass && !cfg_ff.pwr_down ##1 o_ch_out == 3'h7);
	c_force: cover property (i_ce && force_act && ctrl_ff.start_high);
	c_osc_route: cover property (i_ce && route_osc && !cfg_ff.pwr_down);
endmodule : channel_divider_control

// ===== channel_divider_control_bench.sv
`timescale 1ns/1ps
module channel_divider_control_bench;
	// stimulus, all driven at the falling edge
	logic i_clk_sys = 1'b0;
	logic i_resetn = 1'b0;
	logic i_ce = 1'b1;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic [9:0] i_reg_addr = 10'h000;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_sync = 1'b0;
	logic i_dist_lvl = 1'b0;
	logic i_osc_lvl = 1'b0;
	logic i_ext_lvl = 1'b0;
	logic i_drv_invert = 1'b0;
	// observed outputs
	logic [7:0] o_reg_rdata;
	logic [2:0] o_ch_out;
	logic o_div_pd;
	logic o_dcc_en;
	logic [2:0] o_prescale_ratio;
	// bookkeeping
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	// every row that sets force sets the ignore bit too
	// one routing case: registers, input levels {dist,osc,ext,inv}, expected {out,pd,dcc}
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] cfg;
		logic [1:0] src;
		logic [3:0] lv;
		logic [2:0] ex;
	} row_s;
	row_s rows [8] = '{
		'{8'hE0, 8'h00, 2'h0, 4'h8, 3'h7},
		'{8'hE0, 8'h00, 2'h0, 4'h9, 3'h3},
		'{8'h70, 8'h00, 2'h0, 4'h0, 3'h5},
		'{8'h60, 8'h00, 2'h0, 4'h1, 3'h5},
		'{8'h60, 8'h02, 2'h2, 4'h4, 3'h5},
		'{8'h60, 8'h02, 2'h0, 4'h2, 3'h5},
		'{8'h60, 8'h03, 2'h1, 4'h6, 3'h0},
		'{8'h70, 8'h04, 2'h0, 4'hF, 3'h3}
	};
	// divider wave after each edge, oldest in the top bit
	logic [10:0] wave = 11'b00000110001;

	channel_divider_control dut (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_ce(i_ce),
		.i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd),
		.i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata),
		.i_sync(i_sync),
		.i_dist_lvl(i_dist_lvl),
		.i_osc_lvl(i_osc_lvl),
		.i_ext_lvl(i_ext_lvl),
		.i_drv_invert(i_drv_invert),
		.o_reg_rdata(o_reg_rdata),
		.o_ch_out(o_ch_out),
		.o_div_pd(o_div_pd),
		.o_dcc_en(o_dcc_en),
		.o_prescale_ratio(o_prescale_ratio)
	);

	////////////////////////////////////////////////////////////////
	// 20 MHz clock, 50 ns period
	always #25 i_clk_sys = ~i_clk_sys;

	// hang guard: the whole run needs about 150 cycles
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	// compare and count; four-state compare so x never matches
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// let n falling edges pass
	task automatic step(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask : step

	// one-cycle write strobe, then an idle edge so the next call starts clean
	task automatic wr(input logic [9:0] addr, input logic [7:0] data);
		i_reg_wr = 1'b1;
		i_reg_addr = addr;
		i_reg_wdata = data;
		step(1);
		i_reg_wr = 1'b0;
		step(1);
	endtask : wr

	// one-cycle read strobe, data valid after the taking edge
	task automatic rd(input logic [9:0] addr, input logic [7:0] exp);
		i_reg_rd = 1'b1;
		i_reg_addr = addr;
		step(1);
		i_reg_rd = 1'b0;
		chk("rdata", o_reg_rdata, exp);
		step(1);
	endtask : rd

	// pulse the chip-wide sync for one cycle
	task automatic pulse_sync;
		i_sync = 1'b1;
		step(1);
		i_sync = 1'b0;
	endtask : pulse_sync

	// verdict, the single exit of the run
	task automatic end_of_test;
		if (n_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		step(8);
		// values while reset is still held
		chk("dcc_rst", {7'h00, o_dcc_en}, 8'h01);
		chk("presc_rst", {5'h00, o_prescale_ratio}, 8'h00);
		i_resetn = 1'b1;
		step(1);
		// register defaults and an unmapped place
		rd(clkdiv_pkg::ADDR_COUNTS, 8'h00);
		rd(clkdiv_pkg::ADDR_CTRL, 8'h00);
		rd(clkdiv_pkg::ADDR_CFG, 8'h00);
		rd(clkdiv_pkg::ADDR_PRESC, 8'h00);
		wr(10'h100, 8'hFF);
		rd(10'h100, 8'h00);
		// phase field holds its value; unused bits read zero
		wr(clkdiv_pkg::ADDR_CTRL, 8'h6A);
		rd(clkdiv_pkg::ADDR_CTRL, 8'h6A);
		wr(clkdiv_pkg::ADDR_CFG, 8'hF8);
		rd(clkdiv_pkg::ADDR_CFG, 8'h00);
		wr(clkdiv_pkg::ADDR_PRESC, 8'hFD);
		rd(clkdiv_pkg::ADDR_PRESC, 8'h05);
		chk("presc", {5'h00, o_prescale_ratio}, 8'h05);
		// nothing is taken while the clock enable is low
		i_ce = 1'b0;
		wr(clkdiv_pkg::ADDR_PRESC, 8'h03);
		i_ce = 1'b1;
		chk("presc_frozen", {5'h00, o_prescale_ratio}, 8'h05);
		// routing table
		foreach (rows[i]) begin
			wr(clkdiv_pkg::ADDR_CTRL, rows[i].ctrl);
			wr(clkdiv_pkg::ADDR_CFG, rows[i].cfg);
			wr(clkdiv_pkg::ADDR_SRC, {6'h00, rows[i].src});
			{i_dist_lvl, i_osc_lvl, i_ext_lvl, i_drv_invert} = rows[i].lv;
			step(2);
			chk("ch_out", {5'h00, o_ch_out}, {5'h00, {3{rows[i].ex[2]}}});
			chk("div_pd", {7'h00, o_div_pd}, {7'h00, rows[i].ex[1]});
			chk("dcc_en", {7'h00, o_dcc_en}, {7'h00, rows[i].ex[0]});
		end
		// divider wave: low three, high two, phase two, start low
		{i_dist_lvl, i_osc_lvl, i_ext_lvl, i_drv_invert} = 4'h0;
		wr(clkdiv_pkg::ADDR_CFG, 8'h00);
		wr(clkdiv_pkg::ADDR_COUNTS, 8'h21);
		wr(clkdiv_pkg::ADDR_CTRL, 8'h02);
		pulse_sync();
		for (int k = 10; k >= 0; k--) begin
			step(1);
			chk("wave", {5'h00, o_ch_out}, {5'h00, {3{wave[k]}}});
		end
		// sync ignored: start high, sixteen each, then ignore in the low half
		wr(clkdiv_pkg::ADDR_COUNTS, 8'hFF);
		wr(clkdiv_pkg::ADDR_CTRL, 8'h10);
		pulse_sync();
		step(1);
		chk("start_hi", {5'h00, o_ch_out}, 8'h07);
		step(17);
		wr(clkdiv_pkg::ADDR_CTRL, 8'h50);
		pulse_sync();
		repeat (4) begin
			step(1);
			chk("ignored", {5'h00, o_ch_out}, 8'h00);
		end
		// a second reset brings the prescaler code back to divide by two
		i_resetn = 1'b0;
		step(2);
		i_resetn = 1'b1;
		step(1);
		chk("presc_rst2", {5'h00, o_prescale_ratio}, 8'h00);
		rd(clkdiv_pkg::ADDR_CTRL, 8'h00);
		end_of_test();
	end
endmodule : channel_divider_control_bench
